// ---- verilog/ipio_map.svh ----
// Clock rate, carrier limits, reset values and timing counts for the inverter panel I/O block
`ifndef IPIO_MAP_SVH
`define IPIO_MAP_SVH
`define IPIO_CLK_HZ 125000000
`define IPIO_TICK_1MS_US 1000
`define IPIO_TICK_50US_US 50
`define IPIO_SAMPLE_MS 10
`define IPIO_RELEASE_MIN_MS 100
`define IPIO_FREQ_50_HZ 50
`define IPIO_FREQ_60_HZ 60
`define IPIO_CARRIER_STEP 1
`define IPIO_CARRIER_MIN 200
`define IPIO_CARRIER_MAX 500
`define IPIO_CARRIER_RST 200
`endif

// ---- verilog/ipio_pkg.sv ----
// Types shared by the inverter panel I/O modules
`default_nettype none
package ipio_pkg;
  typedef enum logic [2:0] {
    REL_IDLE = 3'b001,
    REL_LOW = 3'b010,
    REL_ARMED = 3'b100
  } ipio_rel_t;
  typedef enum logic [1:0] {
    ENC_NONE = 2'b00,
    ENC_UP = 2'b01,
    ENC_DOWN = 2'b10
  } ipio_step_t;
endpackage
`default_nettype wire

// ---- verilog/ipio_sync_if.sv ----
// Synchronised panel inputs passed from the synchroniser to the core
`default_nettype none
interface ipio_sync_if;
  logic runReqN;
  logic freqSel;
  logic levelSel;
  logic releaseIn;
  logic encA;
  logic encB;
  logic faultOvcN;
  logic faultGateN;
  logic faultTempN;
  modport src (output runReqN, freqSel, levelSel, releaseIn, encA, encB, faultOvcN,
    faultGateN, faultTempN);
  modport dst (input runReqN, freqSel, levelSel, releaseIn, encA, encB, faultOvcN,
    faultGateN, faultTempN);
endinterface
`default_nettype wire

// ---- verilog/ipio_sync.sv ----
// Two-stage synchroniser for all asynchronous panel and fault inputs
`default_nettype none
module ipio_sync #(
  parameter int WIDTH = 9
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] rawIn,
  ipio_sync_if.src syncOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;
  // Reset to idle levels: inactive-low inputs park high, encoder parks at rest
  // so the quadrature decoder sees no false edge after reset
  localparam logic [WIDTH-1:0] IDLE = WIDTH'(9'h1cd);

  always_comb begin
    next_stage1 = reset_n ? rawIn : IDLE;
    next_stage2 = reset_n ? stage1 : IDLE;
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    stage1 <= next_stage1;
    stage2 <= next_stage2;
  end

  // Bit order fixed by the top-level packing
  assign syncOut.runReqN = stage2[0];
  assign syncOut.freqSel = stage2[1];
  assign syncOut.levelSel = stage2[2];
  assign syncOut.releaseIn = stage2[3];
  assign syncOut.encA = stage2[4];
  assign syncOut.encB = stage2[5];
  assign syncOut.faultOvcN = stage2[6];
  assign syncOut.faultGateN = stage2[7];
  assign syncOut.faultTempN = stage2[8];
endmodule
`default_nettype wire

// ---- verilog/ipio_panel.sv ----
// Inverter front-panel, protection and gate-pairing logic
`include "ipio_map.svh"
`default_nettype none
module ipio_panel #(
  parameter int CLK_HZ = `IPIO_CLK_HZ,
  parameter int TICK_MS_CYC = CLK_HZ / 1000 * `IPIO_TICK_1MS_US / 1000,
  parameter int SAMPLE_MS = `IPIO_SAMPLE_MS,
  parameter int RELEASE_SAMPLES = (`IPIO_RELEASE_MIN_MS + `IPIO_SAMPLE_MS - 1)
    / `IPIO_SAMPLE_MS,
  parameter int PHASE_W = 16,
  parameter int CARR_W = 10
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic run_request_n,
  input wire logic out_freq_sel,
  input wire logic level_mode_sel,
  input wire logic alarm_release_in,
  input wire logic encoder_phase_a,
  input wire logic encoder_phase_b,
  input wire logic over_volt_current_fault_n,
  input wire logic gate_driver_fault_n,
  input wire logic over_temp_fault_n,
  input wire logic [CARR_W-1:0] init_carrier_setting_in,
  input wire logic [2:0] pwmHigh,
  input wire logic [2:0] pwmLow,
  output logic run_state_led_out,
  output logic alarm_led_out,
  output logic u_high_gate,
  output logic v_high_gate,
  output logic w_high_gate,
  output logic u_low_gate,
  output logic v_low_gate,
  output logic w_low_gate,
  output logic u_neutral_gate_lo_pair,
  output logic v_neutral_gate_lo_pair,
  output logic w_neutral_gate_lo_pair,
  output logic u_neutral_gate_hi_pair,
  output logic v_neutral_gate_hi_pair,
  output logic w_neutral_gate_hi_pair,
  output logic running,
  output logic threeLevel,
  output logic freq50,
  output logic [CARR_W-1:0] carrierSetting,
  output logic tick1ms,
  output logic tick50us,
  output logic [PHASE_W-1:0] phaseCount
);
  localparam int TICK50_CYC = CLK_HZ / 1000000 * `IPIO_TICK_50US_US;
  localparam logic [CARR_W-1:0] CARR_MIN = CARR_W'(`IPIO_CARRIER_MIN);
  localparam logic [CARR_W-1:0] CARR_MAX = CARR_W'(`IPIO_CARRIER_MAX);
  localparam logic [CARR_W-1:0] CARR_STEP = CARR_W'(`IPIO_CARRIER_STEP);

  ipio_sync_if sync ();

  // Synchronise every asynchronous input before use
  ipio_sync #(.WIDTH(9)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .rawIn({over_temp_fault_n, gate_driver_fault_n, over_volt_current_fault_n,
      encoder_phase_b, encoder_phase_a, alarm_release_in, level_mode_sel,
      out_freq_sel, run_request_n}),
    .syncOut(sync)
  );

  // Timebase state
  logic [16:0] cnt1ms, next_cnt1ms;
  logic [12:0] cnt50, next_cnt50;
  logic [7:0] cntSample, next_cntSample;
  logic next_tick1ms, next_tick50us, sampleTick, next_sampleTick;
  logic [PHASE_W-1:0] next_phaseCount;

  // Tick generators; phase counter advances per 50 us step
  always_comb begin
    next_cnt1ms = cnt1ms + 17'h1;
    next_tick1ms = 1'b0;
    next_cnt50 = cnt50 + 13'h1;
    next_tick50us = 1'b0;
    next_cntSample = cntSample;
    next_sampleTick = 1'b0;
    next_phaseCount = phaseCount;
    if (cnt1ms == 17'(TICK_MS_CYC - 1)) begin
      next_cnt1ms = 17'h0;
      next_tick1ms = 1'b1;
      next_cntSample = cntSample + 8'h1;
      if (cntSample == 8'(SAMPLE_MS - 1)) begin
        next_cntSample = 8'h0;
        next_sampleTick = 1'b1;
      end
    end
    if (cnt50 == 13'(TICK50_CYC - 1)) begin
      next_cnt50 = 13'h0;
      next_tick50us = 1'b1;
      // Adds the selected output rate, 50 or 60, on each step; cleared to zero on each step while stopped
      next_phaseCount = running ? phaseCount + (freq50 ? PHASE_W'(`IPIO_FREQ_50_HZ)
        : PHASE_W'(`IPIO_FREQ_60_HZ)) : '0;
    end
    if (!reset_n) begin
      next_cnt1ms = 17'h0;
      next_cnt50 = 13'h0;
      next_cntSample = 8'h0;
      next_tick1ms = 1'b0;
      next_tick50us = 1'b0;
      next_sampleTick = 1'b0;
      next_phaseCount = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    cnt1ms <= next_cnt1ms;
    cnt50 <= next_cnt50;
    cntSample <= next_cntSample;
    tick1ms <= next_tick1ms;
    tick50us <= next_tick50us;
    sampleTick <= next_sampleTick;
    phaseCount <= next_phaseCount;
  end

  // Control state
  ipio_pkg::ipio_rel_t relState, next_relState;
  logic [7:0] relCount, next_relCount;
  logic alarm, next_alarm, next_running, next_threeLevel, next_freq50;
  logic levelTaken, next_levelTaken;
  logic [1:0] levelWait, next_levelWait;
  logic [CARR_W-1:0] next_carrierSetting;
  logic [1:0] encPrev, next_encPrev;
  logic [1:0] encAcc, next_encAcc;
  logic faultNow, releaseOk;
  ipio_pkg::ipio_step_t encStep;

  // Any low fault line is a fault
  assign faultNow = !sync.faultOvcN || !sync.faultGateN || !sync.faultTempN;

  // Quadrature decode, one step per valid edge
  always_comb begin
    encStep = ipio_pkg::ENC_NONE;
    unique case ({encPrev, sync.encA, sync.encB})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: encStep = ipio_pkg::ENC_UP;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: encStep = ipio_pkg::ENC_DOWN;
      default: encStep = ipio_pkg::ENC_NONE;
    endcase
  end

  assign releaseOk = (relState == ipio_pkg::REL_ARMED) && sync.releaseIn && sampleTick;

  // Release sequencer, alarm latch, run, mode and carrier control
  always_comb begin
    next_relState = relState;
    next_relCount = relCount;
    next_alarm = alarm;
    next_running = running;
    next_threeLevel = threeLevel;
    // Mode taken once the synchroniser holds the pin, not its reset value
    next_levelWait = (levelWait == 2'h2) ? levelWait : levelWait + 2'h1;
    next_levelTaken = (levelWait == 2'h2);
    next_freq50 = freq50;
    next_carrierSetting = carrierSetting;
    next_encPrev = {sync.encA, sync.encB};
    next_encAcc = encAcc;
    if (sampleTick) begin
      unique case (relState)
        ipio_pkg::REL_IDLE: if (!sync.releaseIn) begin
          next_relState = ipio_pkg::REL_LOW;
          next_relCount = 8'h1;
        end
        ipio_pkg::REL_LOW: if (sync.releaseIn) begin
          next_relState = ipio_pkg::REL_IDLE;
        end else begin
          next_relCount = relCount + 8'h1;
          if (relCount + 8'h1 >= 8'(RELEASE_SAMPLES)) next_relState = ipio_pkg::REL_ARMED;
        end
        ipio_pkg::REL_ARMED: if (sync.releaseIn) next_relState = ipio_pkg::REL_IDLE;
        default: next_relState = ipio_pkg::REL_IDLE;
      endcase
    end
    // Fault set wins over release
    if (releaseOk && !faultNow) next_alarm = 1'b0;
    if (faultNow) next_alarm = 1'b1;
    if (!levelTaken) next_threeLevel = sync.levelSel;
    if (sampleTick) begin
      if (!running) next_freq50 = sync.freqSel;
      // Start waits for the sample after a release, never the same one
      next_running = !sync.runReqN && !alarm;
    end
    if (faultNow || next_alarm) next_running = 1'b0;
    if (!running) begin
      next_carrierSetting = init_carrier_setting_in;
      next_encAcc = 2'h0;
    end else if (encStep != ipio_pkg::ENC_NONE) begin
      // Four edges make one pulse cycle
      next_encAcc = encAcc + 2'h1;
      if (encAcc == 2'h3) begin
        if (encStep == ipio_pkg::ENC_UP && carrierSetting < CARR_MAX)
          next_carrierSetting = carrierSetting + CARR_STEP;
        if (encStep == ipio_pkg::ENC_DOWN && carrierSetting > CARR_MIN)
          next_carrierSetting = carrierSetting - CARR_STEP;
      end
    end
    if (!reset_n) begin
      next_relState = ipio_pkg::REL_IDLE;
      next_relCount = 8'h0;
      next_alarm = 1'b0;
      next_running = 1'b0;
      next_threeLevel = 1'b0;
      next_levelTaken = 1'b0;
      next_levelWait = 2'h0;
      next_freq50 = 1'b0;
      next_carrierSetting = CARR_W'(`IPIO_CARRIER_RST);
      next_encPrev = 2'h0;
      next_encAcc = 2'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    relState <= next_relState;
    relCount <= next_relCount;
    alarm <= next_alarm;
    running <= next_running;
    threeLevel <= next_threeLevel;
    levelTaken <= next_levelTaken;
    levelWait <= next_levelWait;
    freq50 <= next_freq50;
    carrierSetting <= next_carrierSetting;
    encPrev <= next_encPrev;
    encAcc <= next_encAcc;
  end

  // Gate outputs registered; alarm forces every gate low
  logic [11:0] gates, next_gates;
  always_comb begin
    next_gates = {pwmHigh, pwmLow, ~pwmLow, ~pwmHigh};
    if (!running || faultNow || alarm || !reset_n) next_gates = 12'h000;
  end

  always_ff @(posedge clk_sys) begin
    gates <= next_gates;
    run_state_led_out <= reset_n ? !running : 1'b1;
    alarm_led_out <= reset_n ? alarm : 1'b0;
  end

  assign {u_high_gate, v_high_gate, w_high_gate} = gates[11:9];
  assign {u_low_gate, v_low_gate, w_low_gate} = gates[8:6];
  assign {u_neutral_gate_lo_pair, v_neutral_gate_lo_pair, w_neutral_gate_lo_pair} = gates[5:3];
  assign {u_neutral_gate_hi_pair, v_neutral_gate_hi_pair, w_neutral_gate_hi_pair} = gates[2:0];

  a_alarm_kills_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
    alarm |=> !running) else $error("running while alarm held");
  a_fault_sets_alarm: assert property (@(posedge clk_sys) disable iff (!reset_n)
    faultNow |=> alarm ##1 alarm_led_out) else $error("fault did not raise alarm");
  a_gates_idle_stop: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !running |=> gates == 12'h000) else $error("gates active while stopped");
  a_run_led_state: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(running) |=> run_state_led_out == !$past(running)) else $error("run lamp");
  a_level_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
    levelTaken && $past(levelTaken) |-> $stable(threeLevel)) else $error("mode moved");
  a_freq_when_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
    running && $past(running) |-> $stable(freq50)) else $error("freq changed running");
  a_run_on_sample: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(running) |-> $past(sampleTick)) else $error("start off sample");
  a_release_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(alarm) |-> $past(relState) == ipio_pkg::REL_ARMED) else $error("bad release");
  a_carrier_bounds: assert property (@(posedge clk_sys) disable iff (!reset_n)
    running && $past(running) |-> carrierSetting - $past(carrierSetting) <= CARR_STEP
    || $past(carrierSetting) - carrierSetting <= CARR_STEP) else $error("carrier jump");
endmodule
`default_nettype wire

// ---- dv/ipio_field_model.sv ----
// Field-side model: fault detectors, release button and carrier trim encoder
`default_nettype none
module ipio_field_model #(
  parameter int SAMPLE_CYC = 20
) (
  input wire logic clk_sys,
  output var logic alarm_release_in,
  output var logic encoder_phase_a,
  output var logic encoder_phase_b,
  output var logic over_volt_current_fault_n,
  output var logic gate_driver_fault_n,
  output var logic over_temp_fault_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Detectors idle high, button idle high, encoder at rest
  initial begin
    alarm_release_in = 1'b1;
    encoder_phase_a = 1'b0;
    encoder_phase_b = 1'b0;
    over_volt_current_fault_n = 1'b1;
    gate_driver_fault_n = 1'b1;
    over_temp_fault_n = 1'b1;
  end
  // A detector pulls its line low while abnormal
  task automatic setFault(input int idx, input logic level);
    @(negedge clk_sys);
    case (idx)
      0: over_volt_current_fault_n = level;
      1: gate_driver_fault_n = level;
      default: over_temp_fault_n = level;
    endcase
  endtask
  // High, low for a number of sample periods, then high again
  task automatic pressRelease(input int samples);
    @(negedge clk_sys);
    alarm_release_in = 1'b0;
    repeat (samples * SAMPLE_CYC) @(negedge clk_sys);
    alarm_release_in = 1'b1;
    repeat (2 * SAMPLE_CYC) @(negedge clk_sys);
  endtask
  // One full quadrature cycle; B leads A when turning up
  task automatic encStep(input logic up);
    logic [1:0] seq [4];
    if (up) seq = '{2'b01, 2'b11, 2'b10, 2'b00};
    else seq = '{2'b10, 2'b11, 2'b01, 2'b00};
    for (int e = 0; e < 4; e++) begin
      @(negedge clk_sys);
      {encoder_phase_a, encoder_phase_b} = seq[e];
      // Held a few cycles so the synchroniser sees every edge
      repeat (4) @(negedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the inverter panel I/O block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic reset_n;
  logic runReqN;
  logic freqSel;
  logic levelSel;
  logic [9:0] initCarr;
  logic [2:0] pwmHigh;
  logic [2:0] pwmLow;
  wire logic relIn, encA, encB, ovcN, gateN, tempN;
  logic runLed, alarmLed, uh, vh, wh, ul, vl, wl, unl, vnl, wnl, unh, vnh, wnh;
  logic running, threeLevel, freq50, tick1ms, tick50us;
  logic [9:0] carrierSetting;
  logic [15:0] phaseCount, p;
  logic [11:0] gateW;
  int bad_count = 0;
  int comparisons = 0;
  int seed = int'(32'ha8ce005e);
  int k;
  assign gateW = {uh, vh, wh, ul, vl, wl, unl, vnl, wnl, unh, vnh, wnh};
  // Short counts: 10-cycle millisecond, 50-cycle 50 us tick, 20 cycles a sample
  ipio_panel #(.CLK_HZ(1000000), .TICK_MS_CYC(10), .SAMPLE_MS(2)) ipio_panel_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .run_request_n(runReqN),
    .out_freq_sel(freqSel), .level_mode_sel(levelSel), .alarm_release_in(relIn),
    .encoder_phase_a(encA), .encoder_phase_b(encB),
    .over_volt_current_fault_n(ovcN), .gate_driver_fault_n(gateN),
    .over_temp_fault_n(tempN), .init_carrier_setting_in(initCarr),
    .pwmHigh(pwmHigh), .pwmLow(pwmLow), .run_state_led_out(runLed),
    .alarm_led_out(alarmLed), .u_high_gate(uh), .v_high_gate(vh), .w_high_gate(wh),
    .u_low_gate(ul), .v_low_gate(vl), .w_low_gate(wl), .u_neutral_gate_lo_pair(unl),
    .v_neutral_gate_lo_pair(vnl), .w_neutral_gate_lo_pair(wnl),
    .u_neutral_gate_hi_pair(unh), .v_neutral_gate_hi_pair(vnh),
    .w_neutral_gate_hi_pair(wnh), .running(running), .threeLevel(threeLevel),
    .freq50(freq50), .carrierSetting(carrierSetting), .tick1ms(tick1ms),
    .tick50us(tick50us), .phaseCount(phaseCount));
  ipio_field_model #(.SAMPLE_CYC(20)) ipio_field_model_i (
    .clk_sys(clk_sys), .alarm_release_in(relIn), .encoder_phase_a(encA),
    .encoder_phase_b(encB), .over_volt_current_fault_n(ovcN),
    .gate_driver_fault_n(gateN), .over_temp_fault_n(tempN));
  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Expected gate word: high, low, then their complements; all off when idle
  function automatic logic [11:0] expG(input logic on, input logic [2:0] h, input logic [2:0] l);
    return on ? {h, l, ~l, ~h} : 12'h000;
  endfunction
  task automatic summarize();
    $display("counts: comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Bounded wait on the run state; a spent bound ends the run
  task automatic waitRun(input logic want);
    int w;
    w = 0;
    while (running !== want && w < 200) begin
      cyc(1);
      w++;
    end
    if (running !== want) begin
      check("running wait", 16'(want), 16'(running));
      summarize();
    end
  endtask
  task automatic waitTick();
    int w;
    w = 0;
    while (tick50us !== 1'b1 && w < 500) begin
      cyc(1);
      w++;
    end
    if (tick50us !== 1'b1) begin
      check("tick50us wait", 16'h1, 16'(tick50us));
      summarize();
    end
  endtask
  initial begin
    // Idle inputs; level select low, unlike the synchroniser's parked value
    reset_n = 1'b0;
    runReqN = 1'b1;
    freqSel = 1'b0;
    levelSel = 1'b0;
    initCarr = 10'h12c;
    pwmHigh = 3'h0;
    pwmLow = 3'h0;
    // Reset values while reset is still applied
    cyc(20);
    check("run lamp", 16'h1, 16'(runLed));
    check("alarm lamp", 16'h0, 16'(alarmLed));
    check("carrier", 16'd200, 16'(carrierSetting));
    check("gates", 16'h0, 16'(gateW));
    reset_n = 1'b1;
    cyc(6);
    check("three level", 16'h0, 16'(threeLevel));
    levelSel = 1'b1;
    cyc(60);
    check("level held", 16'h0, 16'(threeLevel));
    $display("test reset and level done");
    // Stopped: frequency and start carrier follow the panel, corners 200 and 500
    for (int i = 0; i < 4; i++) begin
      freqSel = i[0];
      initCarr = (i == 0) ? 10'd200 : (i == 3) ? 10'd500 : 10'(200 + ($random(seed) & 255));
      cyc(50);
      check("freq50", 16'(freqSel), 16'(freq50));
      check("start carrier", 16'(initCarr), 16'(carrierSetting));
    end
    ipio_field_model_i.encStep(1'b1);
    cyc(6);
    check("carrier stopped", 16'd500, 16'(carrierSetting));
    $display("test stopped settings done");
    // Start with 50 Hz and a 30.0 kHz carrier
    initCarr = 10'd300;
    cyc(50);
    runReqN = 1'b0;
    waitRun(1'b1);
    cyc(2);
    check("run lamp", 16'h0, 16'(runLed));
    check("carrier at start", 16'd300, 16'(carrierSetting));
    for (int i = 0; i < 8; i++) begin
      pwmHigh = 3'($random(seed));
      pwmLow = 3'($random(seed));
      cyc(1);
      check("gates", 16'(expG(1'b1, pwmHigh, pwmLow)), 16'(gateW));
    end
    // Frequency and start setting locked while running
    freqSel = 1'b0;
    initCarr = 10'd450;
    cyc(50);
    check("freq locked", 16'h1, 16'(freq50));
    check("carrier locked", 16'd300, 16'(carrierSetting));
    for (int i = 0; i < 3; i++) ipio_field_model_i.encStep(1'b1);
    cyc(6);
    check("carrier up", 16'd303, 16'(carrierSetting));
    ipio_field_model_i.encStep(1'b0);
    cyc(6);
    check("carrier down", 16'd302, 16'(carrierSetting));
    k = 0;
    repeat (100) begin
      cyc(1);
      if (tick1ms === 1'b1) k++;
    end
    check("ms ticks", 16'd10, 16'(k));
    waitTick();
    cyc(2);
    p = phaseCount;
    waitTick();
    cyc(2);
    check("phase step", p + 16'd50, phaseCount);
    $display("test running done");
    // Each fault latches the alarm; release only after fault gone and long press
    for (int f = 0; f < 3; f++) begin
      ipio_field_model_i.setFault(f, 1'b0);
      cyc(6);
      check("alarm lamp", 16'h1, 16'(alarmLed));
      check("running", 16'h0, 16'(running));
      check("gates off", 16'h0, 16'(gateW));
      ipio_field_model_i.pressRelease(12);
      check("alarm with fault", 16'h1, 16'(alarmLed));
      ipio_field_model_i.setFault(f, 1'b1);
      ipio_field_model_i.pressRelease(5);
      check("alarm short press", 16'h1, 16'(alarmLed));
      ipio_field_model_i.pressRelease(12);
      check("alarm released", 16'h0, 16'(alarmLed));
      waitRun(1'b1);
    end
    $display("test faults done");
    runReqN = 1'b1;
    waitRun(1'b0);
    cyc(2);
    check("run lamp", 16'h1, 16'(runLed));
    check("gates off", 16'h0, 16'(gateW));
    // Phase clears on the first 50 us step after stopping
    waitTick();
    cyc(1);
    check("phase", 16'h0, phaseCount);
    $display("test stop done");
    // Reset again while running; mode is taken afresh, now high
    runReqN = 1'b0;
    waitRun(1'b1);
    reset_n = 1'b0;
    cyc(4);
    check("run lamp in reset", 16'h1, 16'(runLed));
    check("running in reset", 16'h0, 16'(running));
    check("gates in reset", 16'h0, 16'(gateW));
    reset_n = 1'b1;
    cyc(6);
    check("three level", 16'h1, 16'(threeLevel));
    waitRun(1'b1);
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
